// ### fwp_pkg.sv
/*
 package of the flash write-protection block: status layout, opcodes,
 protected-range decode and timing counts.
 assumes a 20 MHz system clock and a serial link far slower than it.
*/
// What this block does
// - lock set, pin low: status write refused
// - lock set, pin high: status write accepted
// - lock clear: status write accepted at either pin level
// - bit 0 reads busy flag
// - bit 1 reads write latch, reset 0
// - bits 2-4 guard field, bits 5-6 zero
// - bit 7 holds status write lock
// - 1 Mbit guard ranges decode
// - 2 Mbit guard ranges decode
// - 4 Mbit guard ranges decode
// - write instructions need clock count multiple eight
// - pin high: nothing protected
// - pin low: guard and lock protect
// - write instructions need latch set first
// - program or erase into protected range refused
// - full erase only with guard bits zero or pin high
// - latch clears when write completes
package fwp_pkg;

	localparam int          STATUS_BUSY_BIT  = 0;
	localparam int          STATUS_LATCH_BIT = 1;
	localparam int          STATUS_GUARD_LSB = 2;
	localparam int          STATUS_GUARD_MSB = 4;
	localparam int          STATUS_LOCK_BIT  = 7;
	localparam logic [2:0]  GUARD_RESET      = 3'h0;
	localparam logic        LOCK_RESET       = 1'b0;
	localparam logic        LATCH_RESET      = 1'b0;

	localparam logic [7:0]  OP_WRITE_UNLOCK  = 8'h06;
	localparam logic [7:0]  OP_WRITE_RELOCK  = 8'h04;
	localparam logic [7:0]  OP_STATUS_READ   = 8'h05;
	localparam logic [7:0]  OP_STATUS_WRITE  = 8'h01;
	localparam logic [7:0]  OP_PAGE_PROGRAM  = 8'h02;
	localparam logic [7:0]  OP_SECTOR_ERASE  = 8'hd7;
	localparam logic [7:0]  OP_BLOCK_ERASE   = 8'hd8;
	localparam logic [7:0]  OP_FULL_ERASE    = 8'hc7;

	localparam int          CLOCK_HZ             = 20_000_000;
	localparam int          STATUS_WRITE_TIME_NS = 1000;
	localparam int          STATUS_WRITE_CYCLES  =
		(STATUS_WRITE_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;

	typedef enum logic [1:0] {
		FWP_OP_PROGRAM = 2'b00,
		FWP_OP_SECTOR  = 2'b01,
		FWP_OP_BLOCK   = 2'b10,
		FWP_OP_FULL    = 2'b11
	} fwp_op_type;

	// floor of the protected upper region, per density; all set means whole array
	function automatic logic fwp_protected(input logic [23:0] addr,
		input logic [2:0] guard, input int mbit, input logic wp_n);
		logic [23:0] a;
		logic        hit;
		a   = addr;
		hit = 1'b0;
		if (mbit == 1) begin
			a = {7'h00, addr[16:0]};
			case (guard[1:0])
				2'b01:   hit = (a >= 24'h018000);
				2'b10:   hit = (a >= 24'h010000);
				2'b11:   hit = 1'b1;
				default: hit = 1'b0;
			endcase
		end else if (mbit == 2) begin
			a = {6'h00, addr[17:0]};
			case (guard[1:0])
				2'b01:   hit = (a >= 24'h030000);
				2'b10:   hit = (a >= 24'h020000);
				2'b11:   hit = 1'b1;
				default: hit = 1'b0;
			endcase
		end else begin
			a = {5'h00, addr[18:0]};
			case (guard)
				3'b000:  hit = 1'b0;
				3'b001:  hit = (a >= 24'h070000);
				3'b010:  hit = (a >= 24'h060000);
				3'b011:  hit = (a >= 24'h040000);
				default: hit = 1'b1;
			endcase
		end
		return hit & ~wp_n;
	endfunction

endpackage

// ### fwp_top.sv
/*
 write-protection logic of a serial flash: serial instruction intake,
 status register, guard decode and start of internal write cycles.
 assumes the array engine reports completion with a one-cycle pulse on
 this clock; serial pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
module fwp_top #(
	parameter int DENSITY_MBIT = 4
) (
	// clock and reset
	input  wire logic                clock_i,
	input  wire logic                reset_n_i,
	// serial link pins
	input  wire logic                select_n_i,
	input  wire logic                sck_i,
	input  wire logic                mosi_i,
	input  wire logic                write_protect_pin_n_i,
	output logic                     miso_o,
	output logic                     miso_oe_o,
	// array engine
	input  wire logic                array_done_i,
	output logic                     op_start_o,
	output fwp_pkg::fwp_op_type      op_kind_o,
	output logic [23:0]              op_addr_o,
	// status view
	output logic [7:0]               status_o
);
	import fwp_pkg::*;

	typedef struct packed {
		logic        cs_s1;
		logic        cs_s2;
		logic        cs_s3;
		logic        sck_s1;
		logic        sck_s2;
		logic        sck_s3;
		logic        mosi_s1;
		logic        mosi_s2;
		logic        wp_s1;
		logic        wp_s2;
		logic [2:0]  bitcnt;
		logic [2:0]  bytecnt;
		logic [6:0]  shift;
		logic [7:0]  opcode;
		logic [7:0]  data;
		logic [23:0] addr;
		logic        lock;
		logic [2:0]  guard;
		logic        latch;
		logic        busy;
		logic [7:0]  timer;
		logic        miso;
		logic        miso_oe;
		logic        op_start;
		fwp_op_type  op_kind;
		logic [23:0] op_addr;
	} fwp_state_type;

	localparam fwp_state_type STATE_RESET = '{
		cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1,
		lock: LOCK_RESET, guard: GUARD_RESET, latch: LATCH_RESET,
		op_kind: FWP_OP_PROGRAM, default: '0};

	fwp_state_type st;
	fwp_state_type next_st;

	logic [7:0] status_now;
	logic [7:0] byte_now;
	logic       rise;
	logic       fall;
	logic       frame_end;
	logic       whole;
	logic       locked;
	logic       prot;
	logic       reading;

	// fewest whole bytes a write instruction needs; shorter frames are dropped
	function automatic logic [2:0] fwp_min_bytes(input logic [7:0] op);
		case (op)
			OP_STATUS_WRITE: return 3'h2;
			OP_PAGE_PROGRAM: return 3'h5;
			OP_SECTOR_ERASE: return 3'h4;
			OP_BLOCK_ERASE:  return 3'h4;
			default:         return 3'h1;
		endcase
	endfunction

	// kind reported to the array engine for each starting instruction
	function automatic fwp_op_type fwp_kind_of(input logic [7:0] op);
		case (op)
			OP_PAGE_PROGRAM: return FWP_OP_PROGRAM;
			OP_SECTOR_ERASE: return FWP_OP_SECTOR;
			OP_BLOCK_ERASE:  return FWP_OP_BLOCK;
			default:         return FWP_OP_FULL;
		endcase
	endfunction

	always_comb begin
		status_now = 8'h00;
		status_now[STATUS_BUSY_BIT] = st.busy;
		status_now[STATUS_LATCH_BIT] = st.latch;
		status_now[STATUS_GUARD_MSB:STATUS_GUARD_LSB] = st.guard;
		status_now[STATUS_LOCK_BIT] = st.lock;
		rise      = st.sck_s2 & ~st.sck_s3 & ~st.cs_s2;
		fall      = ~st.sck_s2 & st.sck_s3 & ~st.cs_s2;
		frame_end = st.cs_s2 & ~st.cs_s3;
		byte_now  = {st.shift, st.mosi_s2};
		whole     = (st.bitcnt == 3'h0) && (st.bytecnt != 3'h0);
		locked    = st.lock & ~st.wp_s2;
		prot      = fwp_protected(st.addr, st.guard, DENSITY_MBIT, st.wp_s2);
		reading   = (st.opcode == OP_STATUS_READ) && (st.bytecnt != 3'h0);

		next_st          = st;
		next_st.cs_s1    = select_n_i;
		next_st.cs_s2    = st.cs_s1;
		next_st.cs_s3    = st.cs_s2;
		next_st.sck_s1   = sck_i;
		next_st.sck_s2   = st.sck_s1;
		next_st.sck_s3   = st.sck_s2;
		next_st.mosi_s1  = mosi_i;
		next_st.mosi_s2  = st.mosi_s1;
		next_st.wp_s1    = write_protect_pin_n_i;
		next_st.wp_s2    = st.wp_s1;
		next_st.op_start = 1'b0;

		// frame start: counters restart so a partial earlier frame cannot leak in
		if (~st.cs_s2 & st.cs_s3) begin
			next_st.bitcnt  = 3'h0;
			next_st.bytecnt = 3'h0;
		end

		if (rise) begin
			next_st.shift  = byte_now[6:0];
			next_st.bitcnt = st.bitcnt + 3'h1;
			if (st.bitcnt == 3'h7) begin
				case (st.bytecnt)
					3'h0: next_st.opcode = byte_now;
					3'h1: begin
						next_st.data        = byte_now;
						next_st.addr[23:16] = byte_now;
					end
					3'h2: next_st.addr[15:8] = byte_now;
					3'h3: next_st.addr[7:0]  = byte_now;
					default: next_st.addr = st.addr;
				endcase
				if (st.bytecnt != 3'h7) begin
					next_st.bytecnt = st.bytecnt + 3'h1;
				end
			end
		end

		// status shifts out on falling edges and loops while selected
		if (fall && reading) begin
			next_st.miso = status_now[3'h7 - st.bitcnt];
		end
		next_st.miso_oe = ~st.cs_s2 && reading;

		// while busy every instruction but status read is dropped
		if (frame_end && whole && !st.busy) begin
			case (st.opcode)
				OP_WRITE_UNLOCK: next_st.latch = 1'b1;
				OP_WRITE_RELOCK: next_st.latch = 1'b0;
				OP_STATUS_WRITE: begin
					if (st.latch && !locked && st.bytecnt >= fwp_min_bytes(st.opcode)) begin
						next_st.lock  = st.data[STATUS_LOCK_BIT];
						next_st.guard = st.data[STATUS_GUARD_MSB:STATUS_GUARD_LSB];
						next_st.busy  = 1'b1;
						next_st.timer = 8'(STATUS_WRITE_CYCLES);
					end
				end
				OP_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE: begin
					if (st.latch && !prot && st.bytecnt >= fwp_min_bytes(st.opcode)) begin
						next_st.busy     = 1'b1;
						next_st.op_start = 1'b1;
						next_st.op_addr  = st.addr;
						next_st.op_kind  = fwp_kind_of(st.opcode);
					end
				end
				OP_FULL_ERASE: begin
					// the pin releases guard protection, full erase included
					if (st.latch && (st.guard == 3'h0 || st.wp_s2)) begin
						next_st.busy     = 1'b1;
						next_st.op_start = 1'b1;
						next_st.op_addr  = 24'h000000;
						next_st.op_kind  = fwp_kind_of(st.opcode);
					end
				end
				default: next_st.latch = st.latch;
			endcase
		end

		// completion of the running cycle
		if (st.busy) begin
			if (st.timer != 8'h00) begin
				next_st.timer = st.timer - 8'h01;
				if (st.timer == 8'h01) begin
					next_st.busy  = 1'b0;
					next_st.latch = 1'b0;
				end
			end else if (array_done_i) begin
				next_st.busy  = 1'b0;
				next_st.latch = 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign miso_o     = st.miso;
	assign miso_oe_o  = st.miso_oe;
	assign op_start_o = st.op_start;
	assign op_kind_o  = st.op_kind;
	assign op_addr_o  = st.op_addr;
	assign status_o   = {st.lock, 2'b00, st.guard, st.latch, st.busy};

endmodule // fwp_top

// ### fwp_top_asserts.sv
/*
 port checker for fwp_top.
 assumes the default four megabit array and one system clock domain.
*/
`timescale 1ns/1ns
module fwp_top_asserts (
	// clock and reset
	input  wire logic           clock_i,
	input  wire logic           reset_n_i,
	// pins and engine
	input  wire logic           write_protect_pin_n_i,
	input  wire logic           array_done_i,
	input  wire logic           op_start_o,
	input  fwp_pkg::fwp_op_type op_kind_o,
	input  wire logic [23:0]    op_addr_o,
	input  wire logic [7:0]     status_o
);
	import fwp_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	AST_RESERVED_ZERO: assert property (status_o[6:5] == 2'b00)
		else $error("reserved status bits not zero");
	AST_START_BUSY: assert property (op_start_o |-> ##[0:1] status_o[0])
		else $error("start without busy");
	AST_START_LATCH: assert property (!status_o[1] |-> !op_start_o)
		else $error("start without write latch");
	AST_DONE_CLEAR: assert property (array_done_i && status_o[0] |=> !status_o[1:0])
		else $error("busy or latch left after done");
	// the design sees the pin through its synchroniser, three samples late
	AST_FULL_GUARD: assert property (op_start_o && op_kind_o == FWP_OP_FULL
		&& !$past(write_protect_pin_n_i, 3) |-> status_o[4:2] == 3'h0)
		else $error("full erase with guard set");
	AST_LOCKED: assert property ((status_o[7] && !write_protect_pin_n_i)[*5]
		|=> $stable(status_o[7:2]))
		else $error("locked status changed");
	AST_PROT_ADDR: assert property (op_start_o && !$past(write_protect_pin_n_i, 3)
		&& status_o[4:2] == 3'h1 |-> op_addr_o[18:0] < 19'h70000)
		else $error("start inside guarded range");
	AST_BUSY_LEN: assert property ($rose(status_o[0]) && !op_start_o &&
		!$past(op_start_o) |-> ##19 status_o[0] ##1 !status_o[0])
		else $error("status write busy length wrong");
	COV_START: cover property (op_start_o);
	COV_READY: cover property ($fell(status_o[0]));
	COV_LOCKED: cover property (status_o[7] && !write_protect_pin_n_i);
	COV_FULL: cover property (op_start_o && op_kind_o == FWP_OP_FULL);
endmodule // fwp_top_asserts

bind fwp_top fwp_top_asserts i_fwp_top_asserts (
	.clock_i(clock_i), .reset_n_i(reset_n_i),
	.write_protect_pin_n_i(write_protect_pin_n_i), .array_done_i(array_done_i),
	.op_start_o(op_start_o), .op_kind_o(op_kind_o), .op_addr_o(op_addr_o),
	.status_o(status_o));

// ### fwp_host_model.sv
/*
 serial host model, mode 0, msb first, frames may be cut short.
 assumes the bench system clock; sck stands low outside frames.
*/
`timescale 1ns/1ns
module fwp_host_model (
	// system clock
	input  wire logic       clock_i,
	// serial link
	output logic            select_n_o,
	output logic            sck_o,
	output logic            mosi_o,
	input  wire logic       miso_i,
	// last bits read back
	output logic [7:0]      rx_o
);
	initial begin
		select_n_o = 1'b1;
		sck_o      = 1'b0;
		mosi_o     = 1'b0;
		rx_o       = 8'h00;
	end
	// four clocks a half period gives a 400 ns link clock
	task automatic frame(input logic [39:0] bits, input int n);
		@(posedge clock_i) select_n_o <= 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge clock_i);
			sck_o  <= 1'b0;
			mosi_o <= bits[39-i];
			repeat (4) @(posedge clock_i);
			sck_o <= 1'b1;
			rx_o  <= {rx_o[6:0], miso_i};
		end
		repeat (4) @(posedge clock_i);
		sck_o  <= 1'b0;
		mosi_o <= ~mosi_o; // released line must not look held
		repeat (4) @(posedge clock_i);
		select_n_o <= 1'b1;
	endtask
endmodule // fwp_host_model

// ### tb.sv
/*
 testbench of fwp_top: status writes, locks, guard and program starts.
 assumes the host model as far side and default array size.
*/
`timescale 1ns/1ns
module tb;
	import fwp_pkg::*;
	logic        clock_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        wp_n = 1'b0;
	logic        done = 1'b0;
	logic        sel_n, sck, mosi, miso, oe, start;
	fwp_op_type  kind;
	logic [23:0] addr;
	logic [7:0]  status, rx;
	int          failures = 0;
	int          samples_checked = 0;
	int          starts = 0;
	int          oe_cycles = 0;
	always #25 clock_i = ~clock_i;
	// an unknown pulse counts, so it cannot hide behind an expected zero
	always @(posedge clock_i) if (reset_n_i && start !== 1'b0) starts <= starts + 1;
	always @(posedge clock_i) if (reset_n_i && oe !== 1'b0) oe_cycles <= oe_cycles + 1;
	fwp_top i_fwp_top (.clock_i(clock_i), .reset_n_i(reset_n_i), .select_n_i(sel_n),
		.sck_i(sck), .mosi_i(mosi), .write_protect_pin_n_i(wp_n), .miso_o(miso),
		.miso_oe_o(oe), .array_done_i(done), .op_start_o(start), .op_kind_o(kind),
		.op_addr_o(addr), .status_o(status));
	fwp_host_model i_fwp_host_model (.clock_i(clock_i), .select_n_o(sel_n),
		.sck_o(sck), .mosi_o(mosi), .miso_i(oe === 1'b1 ? miso : ~miso), .rx_o(rx));
	task automatic check(input string what, input logic [23:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic send(input logic [39:0] bits, input int n);
		i_fwp_host_model.frame(bits, n);
		repeat (8) @(posedge clock_i);
	endtask
	task automatic finish_op;
		done <= 1'b1;
		@(posedge clock_i);
		done <= 1'b0;
		repeat (2) @(posedge clock_i);
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_ready;
		int k;
		for (k = 0; k < 100 && status[0] !== 1'b0; k++) @(posedge clock_i);
		if (k == 100) begin
			failures++;
			test_done;
		end
	endtask
	initial begin
		repeat (2) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		check("status", status, 8'h00);
		send({8'h01, 8'h1c, 24'h0}, 16);
		check("status", status, 8'h00);
		send({8'h06, 32'h0}, 8);
		check("status", status, 8'h02);
		send({8'h01, 8'hff, 24'h0}, 16);
		check("status", status, 8'h9f);
		wait_ready;
		check("status", status, 8'h9c);
		send({8'h05, 32'h0}, 16);
		check("read", rx, 8'h9c);
		check("oe", 24'(oe), 24'h0);
		check("oe", 24'(oe_cycles >= 64 && oe_cycles <= 80), 24'h1);
		send({8'h06, 32'h0}, 8);
		send({8'h01, 8'h00, 24'h0}, 16);
		check("status", status, 8'h9e);
		wp_n <= 1'b1;
		send({8'h01, 8'h84, 24'h0}, 15);
		check("status", status, 8'h9e);
		send({8'h01, 8'h84, 24'h0}, 16);
		check("status", status, 8'h87);
		wait_ready;
		send({8'h06, 32'h0}, 8);
		wp_n <= 1'b0;
		send({8'hc7, 32'h0}, 8);
		check("starts", 24'(starts), 24'h0);
		send({8'h02, 24'h070000, 8'haa}, 40);
		check("starts", 24'(starts), 24'h0);
		check("status", status, 8'h86);
		send({8'h02, 24'h06fff0, 8'haa}, 40);
		check("starts", 24'(starts), 24'h1);
		check("addr", addr, 24'h06fff0);
		check("kind", 24'(kind), 24'(FWP_OP_PROGRAM));
		check("status", status, 8'h87);
		finish_op;
		check("status", status, 8'h84);
		send({8'h06, 32'h0}, 8);
		send({8'h04, 32'h0}, 8);
		check("status", status, 8'h84);
		send({8'h06, 32'h0}, 8);
		send({8'hd7, 24'h07f000, 8'h00}, 32);
		check("starts", 24'(starts), 24'h1);
		check("status", status, 8'h86);
		send({8'hd8, 24'h010000, 8'h00}, 32);
		check("starts", 24'(starts), 24'h2);
		check("addr", addr, 24'h010000);
		check("kind", 24'(kind), 24'(FWP_OP_BLOCK));
		send({8'h04, 32'h0}, 8);
		check("status", status, 8'h87);
		finish_op;
		check("status", status, 8'h84);
		wp_n <= 1'b1;
		send({8'h06, 32'h0}, 8);
		send({8'hc7, 32'h0}, 8);
		check("starts", 24'(starts), 24'h3);
		check("kind", 24'(kind), 24'(FWP_OP_FULL));
		check("addr", addr, 24'h000000);
		finish_op;
		send({8'h06, 32'h0}, 8);
		send({8'hd7, 24'h07f000, 8'h00}, 32);
		check("starts", 24'(starts), 24'h4);
		check("kind", 24'(kind), 24'(FWP_OP_SECTOR));
		check("addr", addr, 24'h07f000);
		finish_op;
		check("status", status, 8'h84);
		check("oe", 24'(oe), 24'h0);
		check("oe", 24'(oe_cycles >= 64 && oe_cycles <= 80), 24'h1);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		check("status", status, 8'h00);
		test_done;
	end
endmodule // tb
